// ===== logic/wb_cache.sv
// Direct-mapped write-back data cache with an APB control port.
// Assumes one clock, a simple word memory port that answers with mem_ack,
// and a processor port that holds its request until cpu_ack.
//
// Operation
// [RULE1] The cache has no snoop port and never reacts to other masters.
// [RULE2] Dirty data leaves the cache only on replacement or explicit flush.
// [RULE3] External writes to memory never alter a cached copy.
// [RULE4] The cache never supplies data to external readers of memory.
// [RULE5] A store miss fetches the whole line first, then merges the bytes.
// [RULE6] A store hit updates only the cached line and sets it dirty.
// [RULE7] A dirty victim is written back whole before the entry is reused.
// [RULE8] Every line holds a valid flag and a dirty flag.
// [RULE9] Every line holds 32 bytes as eight 32-bit words.
// [RULE10] The info and way select bits may be written at any time freely.
// [RULE11] Line flush writes back a dirty hit, invalidates it, else nothing.
// [RULE12] A reloaded line is valid, clean and equals the memory read.
//
// Our own choices: the address map and the APB interface to the registers.
`include "wb_cache_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module wb_cache
  import wb_cache_pkg::*;
#(
  parameter int SETS = 16,
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Processor load/store port
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic [3:0] cpu_be,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_ack,
  output logic [31:0] cpu_rdata,
  // Memory port, word transfers
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr
);
  localparam int IDX_W = $clog2(SETS);
  localparam int OFF_W = $clog2(`LINE_BYTES);
  localparam int TAG_W = ADDR_W - IDX_W - OFF_W;

  // ==========================================================
  // Storage
  // One valid, one dirty flag per line; eight words per line
  logic valid [SETS]; // see [RULE8]
  logic dirty [SETS]; // see [RULE8]
  logic [TAG_W-1:0] tag [SETS];
  logic [31:0] data [SETS][`LINE_WORDS]; // see [RULE9]
  cache_state_t state;
  logic [`WORD_SEL_W-1:0] word_cnt;
  logic [ADDR_W-1:0] op_addr;
  logic cache_info_select;
  logic cache_way_select;
  logic [ADDR_W-1:0] cmd_addr;
  logic flush_hit;
  logic [31:0] mem_wdata_q;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Decode
  wire [IDX_W-1:0] cpu_idx = cpu_addr[OFF_W +: IDX_W];
  wire [TAG_W-1:0] cpu_tag = cpu_addr[ADDR_W-1 -: TAG_W];
  wire [`WORD_SEL_W-1:0] cpu_word = cpu_addr[2 +: `WORD_SEL_W];
  wire [IDX_W-1:0] op_idx = op_addr[OFF_W +: IDX_W];
  wire [TAG_W-1:0] op_tag = op_addr[ADDR_W-1 -: TAG_W];
  wire cpu_hit = valid[cpu_idx] && (tag[cpu_idx] == cpu_tag);
  wire [IDX_W-1:0] cmd_idx = cmd_addr[OFF_W +: IDX_W];
  wire [TAG_W-1:0] cmd_tag = cmd_addr[ADDR_W-1 -: TAG_W];
  wire cmd_hit = valid[cmd_idx] && (tag[cmd_idx] == cmd_tag);
  wire apb_wr = psel && penable && pwrite;
  wire flush_go = apb_wr && (paddr == `REG_CMD) && (pwdata == `CMD_FLUSH)
                  && (state == st_idle) && !cpu_req;
  wire hit_ack = (state == st_idle) && cpu_req && cpu_hit && !flush_go;
  wire miss_go = (state == st_idle) && cpu_req && !cpu_hit && !flush_go;
  wire last_word = (word_cnt == 3'h7);
  // Processor hit answers in the cycle of the request
  assign cpu_ack = hit_ack;
  assign cpu_rdata = data[cpu_idx][cpu_word];

  // ==========================================================
  // Memory port: no snoop input exists at all
  // Only evictions and flushes write memory; never a store. see [RULE2]
  assign mem_req = (state == st_evict) || (state == st_fill)
                   || (state == st_flush_wb);
  assign mem_we = (state == st_evict) || (state == st_flush_wb); // see [RULE2]
  assign mem_wdata = mem_wdata_q;
  always_comb begin
    mem_addr = '0;
    unique case (state)
      st_evict: mem_addr = {tag[op_idx], op_idx, word_cnt, 2'b00};
      st_fill: mem_addr = {op_tag, op_idx, word_cnt, 2'b00};
      st_flush_wb: mem_addr = {tag[cmd_idx], cmd_idx, word_cnt, 2'b00};
      default: mem_addr = '0;
    endcase
  end
  // Write data from a flop: next word chosen one cycle ahead
  wire [`WORD_SEL_W-1:0] next_word = (mem_ack) ? word_cnt + 3'h1 : word_cnt;
  wire [IDX_W-1:0] wb_idx = (state == st_flush_wb || (state == st_idle
                             && flush_go)) ? cmd_idx : op_idx;
  wire [IDX_W-1:0] start_idx = flush_go ? cmd_idx : cpu_idx;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mem_wdata_q <= 32'h00000000;
    end else if (state == st_idle) begin
      mem_wdata_q <= data[start_idx][0];
    end else begin
      mem_wdata_q <= data[wb_idx][next_word];
    end
  end

  // ==========================================================
  // Controller
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= st_idle;
      word_cnt <= 3'h0;
      op_addr <= '0;
      flush_hit <= 1'b0;
    end else begin
      unique case (state)
        st_idle: begin
          word_cnt <= 3'h0;
          if (flush_go) begin
            flush_hit <= cmd_hit;
            if (cmd_hit && dirty[cmd_idx]) begin
              state <= st_flush_wb; // see [RULE11]
            end else if (cmd_hit) begin
              state <= st_flush_inv;
            end
          end else if (miss_go) begin
            op_addr <= cpu_addr;
            // Dirty victim goes out before reuse. see [RULE7]
            if (valid[cpu_idx] && dirty[cpu_idx]) begin
              state <= st_evict;
            end else begin
              state <= st_fill; // see [RULE5]
            end
          end
        end
        st_evict: begin
          if (mem_ack) begin
            word_cnt <= word_cnt + 3'h1;
            if (last_word) begin
              state <= st_fill;
            end
          end
        end
        st_fill: begin
          if (mem_ack) begin
            word_cnt <= word_cnt + 3'h1;
            if (last_word) begin
              state <= st_merge;
            end
          end
        end
        st_merge: state <= st_idle; // Request is replayed as a hit
        st_flush_wb: begin
          if (mem_ack) begin
            word_cnt <= word_cnt + 3'h1;
            if (last_word) begin
              state <= st_flush_inv;
            end
          end
        end
        st_flush_inv: state <= st_idle;
        default: state <= st_idle;
      endcase
    end
  end

  // ==========================================================
  // Line flags; written only by fills, store hits and flush invalidation
  // No path from foreign bus traffic reaches these. see [RULE3] [RULE4]
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int s = 0; s < SETS; s++) begin
        valid[s] <= 1'b0;
        dirty[s] <= 1'b0;
      end
    end else begin
      if (state == st_fill && mem_ack && last_word) begin
        valid[op_idx] <= 1'b1; // see [RULE12]
        dirty[op_idx] <= 1'b0;
      end
      if (hit_ack && cpu_we) begin
        dirty[cpu_idx] <= 1'b1; // see [RULE6]
      end
      if (state == st_flush_inv) begin
        valid[cmd_idx] <= 1'b0; // see [RULE11]
        dirty[cmd_idx] <= 1'b0;
      end
    end
  end

  // Data and tag: fill copies memory words; store merges bytes
  always_ff @(posedge clock) begin
    if (state == st_fill && mem_ack) begin
      data[op_idx][word_cnt] <= mem_rdata; // see [RULE12]
      tag[op_idx] <= op_tag;
    end
    if (hit_ack && cpu_we) begin
      data[cpu_idx][cpu_word] <=
        merge_bytes(data[cpu_idx][cpu_word], cpu_wdata, cpu_be); // see [RULE5]
    end
  end

  // ==========================================================
  // APB registers
  // Select bits only steer the debug read, so any write is safe
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cache_info_select <= 1'b0;
      cache_way_select <= 1'b0;
      cmd_addr <= '0;
    end else if (apb_wr) begin
      if (paddr == `REG_CONFIG) begin
        cache_info_select <= pwdata[`CFG_INFO_BIT]; // see [RULE10]
        cache_way_select <= pwdata[`CFG_WAY_BIT];
      end
      if (paddr == `REG_CMD_ADDR) begin
        cmd_addr <= pwdata[ADDR_W-1:0];
      end
    end
  end

  // Debug view: tag/flags or first or second data word of the command line
  wire [31:0] dbg_tag = {{(32-TAG_W-2){1'b0}}, valid[cmd_idx],
                         dirty[cmd_idx], tag[cmd_idx]};
  wire [31:0] dbg_word = cache_way_select ? data[cmd_idx][1]
                                          : data[cmd_idx][0];
  wire [31:0] dbg_val = cache_info_select ? dbg_tag : dbg_word;
  wire [31:0] status_val = {30'h0, flush_hit, state != st_idle};
  wire addr_ok = (paddr == `REG_CONFIG) || (paddr == `REG_CMD_ADDR)
                 || (paddr == `REG_CMD) || (paddr == `REG_STATUS)
                 || (paddr == `REG_DEBUG);
  // Flush command write waits while the cache is busy or a processor request is pending
  wire cmd_stall = pwrite && (paddr == `REG_CMD)
                   && (pwdata == `CMD_FLUSH)
                   && ((state != st_idle) || cpu_req);
  assign pready = !cmd_stall;
  assign pslverr = psel && penable && !addr_ok;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `REG_CONFIG: prdata <= {27'h0, cache_info_select, 3'h0,
                                cache_way_select};
        `REG_CMD_ADDR: prdata <= cmd_addr;
        `REG_STATUS: prdata <= status_val;
        `REG_DEBUG: prdata <= dbg_val;
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // Checks
  property p_store_no_write;
    @(posedge clock) disable iff (!resetn)
      (hit_ack && cpu_we) |=> !(mem_req && mem_we) [*1];
  endproperty
  a_store_no_write: assert property (p_store_no_write) // see [RULE6]
    else $error("store hit caused a memory write");

  property p_write_only_wb;
    @(posedge clock) disable iff (!resetn)
      (mem_req && mem_we) |-> (state == st_evict || state == st_flush_wb);
  endproperty
  a_write_only_wb: assert property (p_write_only_wb) // see [RULE2]
    else $error("memory write outside write-back");

  property p_dirty_set;
    @(posedge clock) disable iff (!resetn)
      (hit_ack && cpu_we) |=> dirty[$past(cpu_idx)];
  endproperty
  a_dirty_set: assert property (p_dirty_set) // see [RULE6]
    else $error("store hit left line clean");

  property p_fill_clean;
    @(posedge clock) disable iff (!resetn)
      (state == st_fill && mem_ack && last_word) |=>
        (valid[op_idx] && !dirty[op_idx] && state == st_merge);
  endproperty
  a_fill_clean: assert property (p_fill_clean) // see [RULE12]
    else $error("reloaded line not valid and clean");

  property p_evict_then_fill;
    @(posedge clock) disable iff (!resetn)
      (state == st_evict && mem_ack && last_word) |=> (state == st_fill);
  endproperty
  a_evict_then_fill: assert property (p_evict_then_fill) // see [RULE7]
    else $error("eviction not followed by fill");

  property p_dirty_miss_evicts;
    @(posedge clock) disable iff (!resetn)
      (miss_go && valid[cpu_idx] && dirty[cpu_idx]) |=> (state == st_evict);
  endproperty
  a_dirty_miss_evicts: assert property (p_dirty_miss_evicts) // see [RULE7]
    else $error("dirty victim not written back");

  property p_miss_fills;
    @(posedge clock) disable iff (!resetn)
      (miss_go && !(valid[cpu_idx] && dirty[cpu_idx])) |=> (state == st_fill);
  endproperty
  a_miss_fills: assert property (p_miss_fills) // see [RULE5]
    else $error("clean miss did not fetch line");

  property p_flush_inv;
    @(posedge clock) disable iff (!resetn)
      (state == st_flush_inv) |=> (!valid[$past(cmd_idx)] && state == st_idle);
  endproperty
  a_flush_inv: assert property (p_flush_inv) // see [RULE11]
    else $error("flushed line still valid");

  property p_flush_miss_idle;
    @(posedge clock) disable iff (!resetn)
      (flush_go && !cmd_hit) |=>
        (state == st_idle && !flush_hit && !mem_req);
  endproperty
  a_flush_miss_idle: assert property (p_flush_miss_idle) // see [RULE11]
    else $error("flush of uncached address acted");

  property p_cfg_write;
    @(posedge clock) disable iff (!resetn)
      (apb_wr && paddr == `REG_CONFIG) |=>
        (cache_way_select == $past(pwdata[`CFG_WAY_BIT]))
        && (cache_info_select == $past(pwdata[`CFG_INFO_BIT]));
  endproperty
  a_cfg_write: assert property (p_cfg_write) // see [RULE10]
    else $error("select bit write lost");
endmodule
`default_nettype wire

// ===== logic/wb_cache_consts.svh
// Constants for the write-back data cache: geometry, register map, fields.
// Assumes inclusion by bare name from the cache design file.
`ifndef WB_CACHE_CONSTS_SVH
`define WB_CACHE_CONSTS_SVH
`define LINE_BYTES 32
`define LINE_WORDS 8
`define WORD_SEL_W 3
`define REG_ADDR_W 12
`define REG_CONFIG 12'h000
`define REG_CMD_ADDR 12'h004
`define REG_CMD 12'h008
`define REG_STATUS 12'h00c
`define REG_DEBUG 12'h010
`define CFG_INFO_BIT 4
`define CFG_WAY_BIT 0
`define CMD_FLUSH 32'h00000001
`define STAT_BUSY_BIT 0
`define STAT_FLUSH_HIT_BIT 1
`endif

// ===== logic/wb_cache_pkg.sv
// Types shared by the write-back data cache.
// Assumes the constants header is compiled alongside.
package wb_cache_pkg;
  typedef enum logic [5:0] {
    st_idle = 6'h01,
    st_evict = 6'h02,
    st_fill = 6'h04,
    st_merge = 6'h08,
    st_flush_wb = 6'h10,
    st_flush_inv = 6'h20
  } cache_state_t;
endpackage

// ===== testbench/mem_model.sv
// Word memory behind the cache, shared with outside masters.
// Assumes byte addresses on mem_addr and a request held until mem_ack.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // Clock and pacing
  input wire logic clock,
  input wire logic slow,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  // ==========================================================
  // Storage, open to the bench as an outside master
  logic [31:0] mem [0:4095];
  logic [1:0] wait_cnt;
  logic [11:0] widx;
  assign widx = mem_addr[13:2];
  // Known contents so every fill can be predicted
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    wait_cnt = 2'd0;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 32'h10000000 | i;
    end
  end
  // Answer at once or after three idle cycles
  always @(posedge clock) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;  // Released bus never keeps old data
    if (mem_req && !mem_ack) begin
      if (slow && wait_cnt != 2'd3) begin
        wait_cnt <= wait_cnt + 2'd1;
      end else begin
        wait_cnt <= 2'd0;
        mem_ack <= 1'b1;
        mem_rdata <= mem[widx];
      end
    end
    // Write lands at the edge that sees the acknowledge
    if (mem_req && mem_ack && mem_we) begin
      mem[widx] <= mem_wdata;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the write-back data cache.
// Assumes the cache, its constants header and the memory model.
`timescale 1ns/1ps
`default_nettype none
`include "wb_cache_consts.svh"
module tb_top;
  typedef struct {
    logic we;
    logic [31:0] a;
    logic [3:0] be;
    logic [31:0] d;
    logic [31:0] x;
  } row_t;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic slow = 1'b0;
  logic cpu_req = 1'b0;
  logic cpu_we = 1'b0;
  logic [31:0] cpu_addr = 32'h0;
  logic [3:0] cpu_be = 4'h0;
  logic [31:0] cpu_wdata = 32'h0;
  logic cpu_ack;
  logic [31:0] cpu_rdata;
  logic mem_req;
  logic mem_we;
  logic [31:0] mem_addr;
  logic [31:0] mem_wdata;
  logic mem_ack;
  logic [31:0] mem_rdata;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  int error_cnt = 0;
  int comparisons = 0;
  int wr_cnt = 0;
  logic [31:0] r;
  logic err;
  row_t rows [6];
  // ==========================================================
  // Design, memory and clock
  wb_cache i_wb_cache (.clock(clock), .resetn(resetn), .cpu_req(cpu_req),
    .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_be(cpu_be),
    .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  mem_model i_mem_model (.clock(clock), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  always #12.5 clock = ~clock;
  // Count words written to memory
  always @(posedge clock) begin
    if (mem_req && mem_ack && mem_we) begin
      wr_cnt++;
    end
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // Processor access, held until the acknowledge edge
  task automatic cpu(input logic we, input logic [31:0] a,
      input logic [3:0] be, input logic [31:0] d);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_addr <= a;
    cpu_be <= be;
    cpu_wdata <= d;
    // Load data taken at the edge that sees the acknowledge
    do begin
      @(posedge clock);
    end while (cpu_ack !== 1'b1);
    r = cpu_rdata;
    cpu_req <= 1'b0;
    @(posedge clock);
  endtask
  // APB transfer; the flush command may stretch the access phase
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Access phase ends at the edge where pready is seen high
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic end_of_test;
    $display("counts: %0d compared, %0d wrong", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    end_of_test();
  end
  // ==========================================================
  // Sequence
  initial begin
    rows = '{'{1'b0, 32'h100, 4'h0, 32'h0, 32'h10000040},
      '{1'b1, 32'h104, 4'h3, 32'haabbccdd, 32'h0},
      '{1'b0, 32'h104, 4'h0, 32'h0, 32'h1000ccdd},
      '{1'b1, 32'h208, 4'hc, 32'h11223344, 32'h0},
      '{1'b0, 32'h20c, 4'h0, 32'h0, 32'h10000083},
      '{1'b0, 32'h208, 4'h0, 32'h0, 32'h11220082}};
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk(r, 32'h0);
    done("reset");
    foreach (rows[i]) begin
      cpu(rows[i].we, rows[i].a, rows[i].be, rows[i].d);
      if (!rows[i].we) begin
        chk(r, rows[i].x);
      end
    end
    chk(wr_cnt, 0);
    done("table");
    // Outside master writes; cached copy must not follow
    i_mem_model.mem[12'h041] = 32'hdead0041;
    cpu(1'b0, 32'h104, 4'h0, 32'h0);
    chk(r, 32'h1000ccdd);
    chk(i_mem_model.mem[12'h041], 32'hdead0041);
    done("outside master");
    slow <= 1'b1;
    cpu(1'b0, 32'h1100, 4'h0, 32'h0);
    chk(r, 32'h10000440);
    chk(wr_cnt, 8);
    chk(i_mem_model.mem[12'h040], 32'h10000040);
    chk(i_mem_model.mem[12'h041], 32'h1000ccdd);
    i_mem_model.mem[12'h042] = 32'hcafe0002;
    cpu(1'b0, 32'h108, 4'h0, 32'h0);
    chk(r, 32'hcafe0002);
    chk(wr_cnt, 8);
    done("eviction");
    cpu(1'b1, 32'h20c, 4'hf, 32'h55667788);
    apb(1'b1, `REG_CMD_ADDR, 32'h20c);
    apb(1'b1, `REG_CMD, `CMD_FLUSH);
    // Write-back runs on after the command is taken; poll until idle
    do begin
      apb(1'b0, `REG_STATUS, 32'h0);
    end while (r[`STAT_BUSY_BIT] !== 1'b0);
    chk(i_mem_model.mem[12'h083], 32'h55667788);
    chk(i_mem_model.mem[12'h082], 32'h11220082);
    chk(wr_cnt, 16);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk({31'h0, r[`STAT_FLUSH_HIT_BIT]}, 32'h1);
    apb(1'b1, `REG_CMD, `CMD_FLUSH);
    do begin
      apb(1'b0, `REG_STATUS, 32'h0);
    end while (r[`STAT_BUSY_BIT] !== 1'b0);
    chk(wr_cnt, 16);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk({31'h0, r[`STAT_FLUSH_HIT_BIT]}, 32'h0);
    i_mem_model.mem[12'h083] = 32'h77770083;
    cpu(1'b0, 32'h20c, 4'h0, 32'h0);
    chk(r, 32'h77770083);
    done("flush");
    apb(1'b1, `REG_CONFIG, 32'h11);
    apb(1'b0, `REG_CONFIG, 32'h0);
    chk(r, 32'h11);
    cpu(1'b0, 32'h108, 4'h0, 32'h0);
    chk(r, 32'hcafe0002);
    // Tag view of the flush-address line: valid, clean, tag 1
    apb(1'b0, `REG_DEBUG, 32'h0);
    chk(r, 32'h01000001);
    // Data view, second word of that line
    apb(1'b1, `REG_CONFIG, 32'h01);
    apb(1'b0, `REG_DEBUG, 32'h0);
    chk(r, 32'h10000081);
    apb(1'b0, 12'hffc, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(r, 32'h0);
    done("registers");
    // Reset in mid-run returns the select bits to zero
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    apb(1'b0, `REG_CONFIG, 32'h0);
    chk(r, 32'h0);
    done("mid-run reset");
    end_of_test();
  end
endmodule
`default_nettype wire
